// >>> design/host_port_consts.vh
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH

// ==========================================================================
// Strap encodings
`define WIDTH_SEL_16BIT 1'h0
`define WIDTH_SEL_8BIT 1'h1
`define STYLE_SEL_STROBES 1'h0
`define STYLE_SEL_RW_DS 1'h1

// ==========================================================================
// Data path, address and interrupt source widths
`define HOST_DATA_W 16
`define HOST_ADDR_W 8
`define IRQ_SRC_W 8

// ==========================================================================
// Byte enables
`define BE_WORD 2'h3
`define BE_LOW 2'h1
`define BE_HIGH 2'h2

// ==========================================================================
// Reset values and data drive patterns
`define DATA_OUT_RST 16'h0000
`define DRIVE_OFF_N 16'hFFFF
`define DRIVE_LOW_BYTE_N 16'hFF00
`define DRIVE_WORD_N 16'h0000
`define ADDR_RST 8'h00

// ==========================================================================
// Strap capture: cycles after reset release before straps are taken.
`define STRAP_WAIT_CYC 2'h3

`endif

// >>> design/sync_2ff.v
`timescale 1ns/1ps

// ==========================================================================
// Two-stage synchroniser for a bundle of asynchronous pin levels.
module sync_2ff #(
    parameter WIDTH = 1
) (
    input wire core_clk, // Core clock.
    input wire rst_n, // Asynchronous reset, active low.
    input wire [WIDTH-1:0] async_in, // Pin levels from outside.
    output reg [WIDTH-1:0] sync_out // Levels safe to use in core_clk.
);

reg [WIDTH-1:0] meta_r;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        meta_r <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta_r <= async_in;
        sync_out <= meta_r;
    end
end

endmodule // sync_2ff

// >>> design/addr_latch.v
`timescale 1ns/1ps
`include "host_port_consts.vh"

// ==========================================================================
// Address latch: transparent while the enable is high, holds from its
// falling edge until it rises again. Inputs are already synchronised.
module addr_latch (
    input wire core_clk, // Core clock.
    input wire rst_n, // Asynchronous reset, active low.
    input wire latch_en, // Synchronised address latch enable.
    input wire [`HOST_ADDR_W-1:0] addr_in, // Synchronised address lines.
    output wire [`HOST_ADDR_W-1:0] addr_out // Address seen by the decode.
);

reg [`HOST_ADDR_W-1:0] held_r;

// The held copy follows the lines while open, so on the falling edge it
// keeps the value from the last cycle the enable was still high.
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        held_r <= `ADDR_RST;
    end else if (latch_en) begin
        held_r <= addr_in;
    end
end

// Open latch passes the lines straight through to the decode.
assign addr_out = latch_en ? addr_in : held_r;

endmodule // addr_latch

// >>> design/host_cpu_bus_port.v
`timescale 1ns/1ps
`include "host_port_consts.vh"

module host_cpu_bus_port (
    input wire core_clk, // Core clock, 125 MHz.
    input wire rst_n, // Asynchronous reset, active low.
    input wire bus_width_select, // Strap: 0 = 16-bit, 1 = 8-bit.
    input wire bus_style_select, // Strap: 0 = strobes, 1 = select+strobe.
    input wire chip_select_n, // Host chip select, active low.
    input wire write_strobe_n, // Write strobe, or read_write_select.
    input wire read_strobe_n, // Read strobe, or data_strobe (low active).
    input wire address_latch_enable, // Address latch enable.
    input wire [`HOST_ADDR_W-1:0] host_address_lines, // Register address.
    input wire [`HOST_DATA_W-1:0] host_data_in, // Data lines, input side.
    output reg [`HOST_DATA_W-1:0] host_data_out, // Data lines, output side.
    output reg [`HOST_DATA_W-1:0] host_data_drive_n, // Per-line enable, low drives.
    output reg host_interrupt_out, // Interrupt pin level when driven.
    output reg host_interrupt_drive_n, // Interrupt enable, low pulls pin low.
    output reg [`HOST_ADDR_W-1:0] reg_addr, // Byte address to register file.
    output reg [1:0] reg_byte_en, // Byte lanes of the access.
    output reg [`HOST_DATA_W-1:0] reg_wdata, // Write data to register file.
    output reg reg_wr, // One-cycle write pulse.
    output reg reg_rd, // One-cycle read pulse.
    input wire [`HOST_DATA_W-1:0] reg_rdata, // Read data, valid after reg_rd.
    input wire [`IRQ_SRC_W-1:0] irq_source, // Active interrupt sources.
    input wire [`IRQ_SRC_W-1:0] irq_mask_en, // Source enables, 1 = unmasked.
    output reg mode_8bit, // Captured width strap.
    output reg mode_rw_ds // Captured style strap.
);

// ==========================================================================
// Read sequence states
localparam ST_IDLE = 3'b001;
localparam ST_FETCH = 3'b010;
localparam ST_DRIVE = 3'b100;

// ==========================================================================
// Helpers

// Word accesses clear the lsb; byte accesses keep it.
function [`HOST_ADDR_W-1:0] eff_addr;
    input [`HOST_ADDR_W-1:0] a;
    input narrow;
    begin
        eff_addr = narrow ? a : {a[`HOST_ADDR_W-1:1], 1'b0};
    end
endfunction

function [1:0] lane_sel;
    input [`HOST_ADDR_W-1:0] a;
    input narrow;
    begin
        if (!narrow) begin
            lane_sel = `BE_WORD;
        end else if (a[0]) begin
            lane_sel = `BE_HIGH;
        end else begin
            lane_sel = `BE_LOW;
        end
    end
endfunction

// ==========================================================================
// Pin synchronisation
wire [1:0] strap_s;
wire [3:0] ctl_s;
wire [`HOST_ADDR_W-1:0] addr_s;
wire [`HOST_DATA_W-1:0] data_s;
wire [`HOST_ADDR_W-1:0] addr_l;

sync_2ff #(
    .WIDTH(2)
) u_sync_strap (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({bus_style_select, bus_width_select}),
    .sync_out(strap_s)
);

// Strobes are kept in the inactive level at reset so no false edge is
// seen when the first real samples arrive; low-active pins are inverted.
sync_2ff #(
    .WIDTH(4)
) u_sync_ctl (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({address_latch_enable, ~chip_select_n, ~write_strobe_n,
        ~read_strobe_n}),
    .sync_out(ctl_s)
);

sync_2ff #(
    .WIDTH(`HOST_ADDR_W)
) u_sync_addr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(host_address_lines),
    .sync_out(addr_s)
);

sync_2ff #(
    .WIDTH(`HOST_DATA_W)
) u_sync_data (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(host_data_in),
    .sync_out(data_s)
);

addr_latch u_addr_latch (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .latch_en(ctl_s[3]),
    .addr_in(addr_s),
    .addr_out(addr_l)
);

wire sel_s = ctl_s[2];
wire wr_pin_s = ctl_s[1];
wire rd_pin_s = ctl_s[0];

// ==========================================================================
// Strap capture
// The straps are taken once, after reset release and after the
// synchronisers are filled, so they never change under a live access.
reg [1:0] strap_cnt_r;
reg ready_r;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        strap_cnt_r <= 2'h0;
        ready_r <= 1'b0;
        mode_8bit <= `WIDTH_SEL_16BIT;
        mode_rw_ds <= `STYLE_SEL_STROBES;
    end else if (!ready_r) begin
        if (strap_cnt_r == `STRAP_WAIT_CYC) begin
            mode_8bit <= strap_s[0];
            mode_rw_ds <= strap_s[1];
            ready_r <= 1'b1;
        end else begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
        end
    end
end

// ==========================================================================
// Access qualifiers
// In the select-plus-strobe style the write strobe pin carries the
// read/write select (high = read, so the inverted level is low) and the
// read strobe pin carries the data strobe.
reg rd_act;
reg wr_act;

always @* begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (ready_r && sel_s) begin
        if (!mode_rw_ds) begin
            rd_act = rd_pin_s;
            wr_act = wr_pin_s;
        end else begin
            rd_act = rd_pin_s & ~wr_pin_s;
            wr_act = rd_pin_s & wr_pin_s;
        end
    end
end

// ==========================================================================
// Write path
// Data and address are tracked while the write is active, and committed
// when it ends: the strobe release in either style. Taking data at the
// end lets the host settle the lines during the strobe.
reg wr_act_r;
reg [`HOST_DATA_W-1:0] wdata_hold_r;
reg [`HOST_ADDR_W-1:0] waddr_hold_r;
wire wr_end = wr_act_r & ~wr_act;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        wr_act_r <= 1'b0;
        wdata_hold_r <= `DATA_OUT_RST;
        waddr_hold_r <= `ADDR_RST;
    end else begin
        wr_act_r <= wr_act;
        if (wr_act) begin
            waddr_hold_r <= addr_l;
            if (mode_8bit) begin
                wdata_hold_r <= {data_s[7:0], data_s[7:0]};
            end else begin
                wdata_hold_r <= data_s;
            end
        end
    end
end

// ==========================================================================
// Read sequence
reg [2:0] state_r;
reg [2:0] state_nxt;

always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE: begin
            if (rd_act) begin
                state_nxt = ST_FETCH;
            end
        end
        ST_FETCH: begin
            state_nxt = rd_act ? ST_DRIVE : ST_IDLE;
        end
        ST_DRIVE: begin
            if (!rd_act) begin
                state_nxt = ST_IDLE;
            end
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
end

// ==========================================================================
// Register side and pin outputs
reg [`HOST_ADDR_W-1:0] raddr_r;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= ST_IDLE;
        raddr_r <= `ADDR_RST;
        reg_addr <= `ADDR_RST;
        reg_byte_en <= `BE_WORD;
        reg_wdata <= `DATA_OUT_RST;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        host_data_out <= `DATA_OUT_RST;
        host_data_drive_n <= `DRIVE_OFF_N;
    end else begin
        state_r <= state_nxt;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        if (wr_end) begin
            reg_wr <= 1'b1;
            reg_addr <= eff_addr(waddr_hold_r, mode_8bit);
            reg_byte_en <= lane_sel(waddr_hold_r, mode_8bit);
            reg_wdata <= wdata_hold_r;
        end else if (state_r == ST_IDLE && rd_act) begin
            reg_rd <= 1'b1;
            raddr_r <= addr_l;
            reg_addr <= eff_addr(addr_l, mode_8bit);
            reg_byte_en <= lane_sel(addr_l, mode_8bit);
        end
        // Drive only in the fetch-to-drive step and while the read holds;
        // any drop of select or strobe releases the lines next edge.
        if (state_r == ST_FETCH && rd_act) begin
            if (mode_8bit) begin
                host_data_out <= {8'h00, raddr_r[0] ? reg_rdata[15:8]
                    : reg_rdata[7:0]};
                host_data_drive_n <= `DRIVE_LOW_BYTE_N;
            end else begin
                host_data_out <= reg_rdata;
                host_data_drive_n <= `DRIVE_WORD_N;
            end
        end else if (!rd_act || state_r == ST_IDLE) begin
            host_data_drive_n <= `DRIVE_OFF_N;
        end
    end
end

// ==========================================================================
// Interrupt pin
// Open drain: the level is always low and only the enable moves, so the
// pin is pulled low while any unmasked source stays active.
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        host_interrupt_out <= 1'b0;
        host_interrupt_drive_n <= 1'b1;
    end else begin
        host_interrupt_out <= 1'b0;
        host_interrupt_drive_n <= ~|(irq_source & irq_mask_en);
    end
end

endmodule // host_cpu_bus_port

// >>> verification/host_port_properties.sv
`timescale 1ns/1ps
`include "host_port_consts.vh"

// ==================================================================
// Port checker
module host_port_properties (
    input wire logic core_clk, // Clock.
    input wire logic rst_n, // Reset.
    input wire logic chip_select_n, // Select.
    input wire logic write_strobe_n, // Write or direction.
    input wire logic read_strobe_n, // Read or data strobe.
    input wire logic [7:0] irq_source, // Sources.
    input wire logic [7:0] irq_mask_en, // Enables.
    input wire logic [15:0] host_data_drive_n, // Drive.
    input wire logic host_interrupt_out, // Pin level.
    input wire logic host_interrupt_drive_n, // Pin enable.
    input wire logic [7:0] reg_addr, // Address.
    input wire logic [1:0] reg_byte_en, // Lanes.
    input wire logic reg_wr, // Write.
    input wire logic reg_rd, // Read.
    input wire logic mode_8bit, // Width.
    input wire logic mode_rw_ds // Style.
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire drv = host_data_drive_n != `DRIVE_OFF_N;
    wire irq_act = |(irq_source & irq_mask_en);
    wire xfer = reg_wr || reg_rd;
    logic [2:0] cs_hi_r;
    // Counts idle select cycles, so late commits of an access still pass.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) cs_hi_r <= 3'h0;
        else if (!chip_select_n) cs_hi_r <= 3'h0;
        else if (cs_hi_r != 3'h7) cs_hi_r <= cs_hi_r + 3'h1;
    end
    sequence s_rd_req;
        !chip_select_n && write_strobe_n && $fell(read_strobe_n);
    endsequence
    sequence s_rd_ans;
        ##[1:4] reg_rd ##[1:3] drv;
    endsequence
    a_rd_answer: assert property (s_rd_req |-> s_rd_ans)
        else $error("read gave no pulse or drive");
    a_idle_quiet: assert property (cs_hi_r == 3'h7 |-> !xfer && !drv)
        else $error("activity without select");
    a_drive_sel: assert property (drv |-> !$past(chip_select_n, 4)
        && !$past(read_strobe_n, 4) && $past(write_strobe_n, 4))
        else $error("data driven outside a read");
    a_wr_release: assert property (reg_wr && !mode_rw_ds
        |-> $past(write_strobe_n, 3))
        else $error("write before strobe release");
    a_ds_rise: assert property (reg_wr && mode_rw_ds
        |-> $past(read_strobe_n, 3) && !$past(write_strobe_n, 7))
        else $error("write without strobe rise");
    a_one_pulse: assert property (xfer |=> !xfer)
        else $error("pulse longer than one cycle");
    a_lane_map: assert property (xfer |-> (mode_8bit ?
        reg_byte_en == (reg_addr[0] ? `BE_HIGH : `BE_LOW) :
        reg_byte_en == `BE_WORD && !reg_addr[0]))
        else $error("wrong byte lanes");
    a_upper_free: assert property (mode_8bit |-> &host_data_drive_n[15:8])
        else $error("upper lines driven");
    a_irq_follow: assert property ($past(rst_n) |-> !host_interrupt_out
        && host_interrupt_drive_n == !$past(irq_act))
        else $error("interrupt pin wrong");
endmodule // host_port_properties

// >>> verification/host_bus_model.sv
`timescale 1ns/1ps

// ==================================================================
// Host processor model
module host_bus_model (
    input wire logic core_clk, // Clock.
    input wire logic w8, // Width strap.
    input wire logic st, // Style strap.
    input wire logic [15:0] dev_data, // Device data.
    input wire logic [15:0] dev_drive_n, // Device enable.
    output logic cs_n, // Select.
    output logic wr_n, // Write or direction.
    output logic rd_n, // Read or data strobe.
    output logic ale, // Latch enable.
    output logic [7:0] addr, // Address.
    output logic [15:0] pins // Line levels.
);
    logic oe;
    logic [15:0] hd;
    logic [15:0] last_r = 16'h0000;
    // Released lines toggle each cycle, except the upper byte in 8-bit mode, which is held low, so a stale value never passes.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pins[i] = !dev_drive_n[i] ? dev_data[i] :
                (w8 && i > 7) ? 1'b0 : oe ? hd[i] : ~last_r[i];
        end
    end
    always @(posedge core_clk) last_r <= pins;
    initial begin
        // Latch enable idles high, as for a non-multiplexed bus.
        {cs_n, wr_n, rd_n, ale, oe} = 5'h1E;
        addr = 8'h00;
        hd = 16'h0000;
    end
    task access(input logic rd, sel, mux, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge core_clk) #1;
        addr = a;
        hd = d;
        if (mux) begin
            repeat (3) @(posedge core_clk);
            #1 ale = 0;
            repeat (3) @(posedge core_clk);
            #1 addr = ~a;
        end
        cs_n = !sel;
        oe = !rd;
        wr_n = rd;
        rd_n = st ? 1'b0 : !rd;
        repeat (8) @(posedge core_clk);
        #1 {cs_n, wr_n, rd_n, ale, oe} = 5'h1E;
        repeat (6) @(posedge core_clk);
        #1;
    endtask
endmodule // host_bus_model

// >>> verification/test_host_cpu_bus_port.sv
`timescale 1ns/1ps
`include "host_port_consts.vh"

// ==================================================================
// Bench
module test_host_cpu_bus_port;
    logic core_clk = 0, rst_n = 0, w8 = 0, st = 0, drv_q = 0;
    logic [7:0] irq_source = 0, irq_mask_en = 0, reg_addr;
    logic [7:0] host_address_lines;
    logic [15:0] reg_rdata = 0, host_data_out, host_data_drive_n;
    logic [15:0] host_data_in, reg_wdata;
    logic [1:0] reg_byte_en;
    logic chip_select_n, write_strobe_n, read_strobe_n;
    logic address_latch_enable, host_interrupt_out;
    logic host_interrupt_drive_n, reg_wr, reg_rd, mode_8bit, mode_rw_ds;
    integer seed = 32'hb3e0, n_fail = 0, checks = 0, cyc = 0;
    logic [25:0] wq[$];
    logic [15:0] aq[$], dq[$];
    always #4 core_clk = ~core_clk;
    host_cpu_bus_port u_host_cpu_bus_port (.core_clk, .rst_n,
        .bus_width_select(w8), .bus_style_select(st), .chip_select_n,
        .write_strobe_n, .read_strobe_n, .address_latch_enable,
        .host_address_lines, .host_data_in, .host_data_out,
        .host_data_drive_n, .host_interrupt_out, .host_interrupt_drive_n,
        .reg_addr, .reg_byte_en, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .irq_source, .irq_mask_en, .mode_8bit, .mode_rw_ds);
    host_bus_model u_host_bus_model (.core_clk, .w8, .st,
        .dev_data(host_data_out), .dev_drive_n(host_data_drive_n),
        .cs_n(chip_select_n), .wr_n(write_strobe_n), .rd_n(read_strobe_n),
        .ale(address_latch_enable), .addr(host_address_lines),
        .pins(host_data_in));
    task cmp_w(input logic [25:0] g, e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task cmp_v(input logic [15:0] g, e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task conclude;
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==============================================================
    // Monitor: an empty queue yields unknown, so a stray result fails.
    always @(posedge core_clk) begin
        if (reg_wr === 1'b1) cmp_w({reg_addr, reg_byte_en, reg_wdata},
            wq.size() ? wq.pop_front() : 'x);
        if (reg_rd === 1'b1) cmp_v({8'h00, reg_addr},
            aq.size() ? aq.pop_front() : 'x);
        if (host_data_drive_n !== `DRIVE_OFF_N && !drv_q)
            cmp_v(host_data_in & ~host_data_drive_n,
            dq.size() ? dq.pop_front() : 'x);
        drv_q <= host_data_drive_n !== `DRIVE_OFF_N;
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            conclude;
        end
    end
    // ==============================================================
    // Stimulus
    task op(input logic rd, sel, mux);
        logic [7:0] a, ea;
        logic [15:0] d, r;
        a = $random(seed);
        if (!w8) a[0] = 1'b0;
        d = $random(seed);
        r = $random(seed);
        reg_rdata = r;
        ea = w8 ? a : {a[7:1], 1'b0};
        if (sel && rd) begin
            aq.push_back({8'h00, ea});
            dq.push_back(w8 ? {8'h00, a[0] ? r[15:8] : r[7:0]} : r);
        end else if (sel) begin
            wq.push_back({ea, w8 ? (a[0] ? `BE_HIGH : `BE_LOW) : `BE_WORD,
                w8 ? {2{d[7:0]}} : d});
        end
        u_host_bus_model.access(rd, sel, mux, a, d);
    endtask
    initial begin
        for (int m = 0; m < 4; m++) begin
            #1 rst_n = 0;
            w8 = m[0];
            st = m[1];
            repeat (10) @(posedge core_clk);
            #1 rst_n = 1;
            repeat (8) @(posedge core_clk);
            #1 cmp_v({14'h0000, mode_rw_ds, mode_8bit},
                {14'h0000, st, w8});
            for (int i = 0; i < 6; i++) op(i[0], 1'b1, i[2]);
            op(1'b0, 1'b0, 1'b0);
            op(1'b1, 1'b0, 1'b0);
            for (int i = 0; i < 4; i++) begin
                irq_source = $random(seed);
                irq_mask_en = $random(seed);
                repeat (3) @(posedge core_clk);
                #1 cmp_v({14'h0000, host_interrupt_out,
                    host_interrupt_drive_n},
                    {15'h0000, ~|(irq_source & irq_mask_en)});
            end
        end
        // Every noted result must have appeared by now.
        cmp_v(16'(wq.size() + aq.size() + dq.size()), 16'h0000);
        conclude;
    end
endmodule // test_host_cpu_bus_port

bind host_cpu_bus_port host_port_properties u_host_port_properties (
    .core_clk, .rst_n, .chip_select_n, .write_strobe_n, .read_strobe_n,
    .irq_source, .irq_mask_en, .host_data_drive_n, .host_interrupt_out,
    .host_interrupt_drive_n, .reg_addr, .reg_byte_en, .reg_wr, .reg_rd,
    .mode_8bit, .mode_rw_ds);
